//--- sspr_top.v
// single-slope pressure readout controller with APB registers
// assumes straps change only with power off and an external display driver
//
// What this block does
// - per conversion select polarity, sample counter, release discharge, await captures.
// - a comparator falling edge latches the time base into its capture.
// - time base is a free-running 16-bit up-counter.
// - three channels captured from one ramp: upper, lower, reference.
// - difference captures, swap polarity, convert again, sum and halve.
// - polarity output swaps from first switch pair to second between halves.
// - result is unsigned with at least 11 bits.
// - signal count is divided by reference count, ratiometric result.
// - strap a,b,c decode to speed, pressure, calibrations or range.
// - range codes pick 100, 30 or 15 psi and show it.
// - straps read after power-up; display held off for seconds.
// - zero calibration stores the offset and shows 000.
// - full-scale calibration stores the span and shows FFF.
// - operating display shows speed only at or above the 5 mph threshold.
// - display data go out over SPI as master.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "sspr_consts.vh"
module sspr_top #(
  parameter SETTLE_CYCLES = `SSPR_SETTLE_US * `SSPR_CLK_MHZ,
  parameter STARTUP_CYCLES = `SSPR_STARTUP_MS * 1000 * `SSPR_CLK_MHZ
) (
  input wire CLOCK_IN,
  input wire RST_N_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  input wire [2:0] COMP_IN,
  input wire [2:0] STRAP_N_IN,
  output reg POLARITY_SEL_OUT,
  output reg DISCHARGE_ON_OUT,
  output reg SPI_SCK_OUT,
  output reg SPI_MOSI_OUT,
  output reg SPI_CS_N_OUT
);

localparam [27:0] SETTLE_W = SETTLE_CYCLES[27:0];
localparam [27:0] STARTUP_W = STARTUP_CYCLES[27:0];
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_SETTLE = 3'h1;
localparam [2:0] S_ARM = 3'h2;
localparam [2:0] S_WAIT = 3'h3;
localparam [2:0] S_DIV = 3'h4;
localparam [2:0] S_DONE = 3'h5;

////////////////////////////////////////////////////////////////////////
// straps and power-up delay

reg [2:0] strap_s1;
reg [2:0] strap_s2;
reg [2:0] strap_code;
reg [2:0] mode;
reg strap_ok;
reg show_en;
reg [27:0] boot_cnt;
reg [2:0] next_mode;

always @*
begin
  case (strap_s2)
    `SSPR_STRAP_SPEED0: next_mode = `SSPR_MODE_SPEED;
    `SSPR_STRAP_SPEED1: next_mode = `SSPR_MODE_SPEED;
    `SSPR_STRAP_FULL: next_mode = `SSPR_MODE_FULL;
    `SSPR_STRAP_ZERO: next_mode = `SSPR_MODE_ZERO;
    `SSPR_STRAP_PRESS: next_mode = `SSPR_MODE_PRESS;
    default: next_mode = `SSPR_MODE_RANGE;
  endcase
end

always @(posedge CLOCK_IN)
begin
  if (!RST_N_IN)
  begin
    strap_s1 <= 3'h0;
    strap_s2 <= 3'h0;
    strap_code <= 3'h0;
    mode <= `SSPR_MODE_SPEED;
    strap_ok <= 1'b0;
    show_en <= 1'b0;
    boot_cnt <= 28'h0000000;
  end
  else
  begin
    // jumper in pulls the pin low
    strap_s1 <= ~STRAP_N_IN;
    strap_s2 <= strap_s1;
    if (boot_cnt != STARTUP_W)
      boot_cnt <= boot_cnt + 28'h0000001;
    // straps are read once; changing them needs a fresh power-up
    if (boot_cnt == `SSPR_STRAP_SAMPLE && !strap_ok)
    begin
      strap_code <= strap_s2;
      mode <= next_mode;
      strap_ok <= 1'b1;
    end
    if (boot_cnt == STARTUP_W && strap_ok)
      show_en <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// time base and captures

reg [7:0] tick_cnt;
reg [15:0] time_base;
wire [47:0] caps;
wire [2:0] cap_done;
reg arm;

always @(posedge CLOCK_IN)
begin
  if (!RST_N_IN)
  begin
    tick_cnt <= 8'h00;
    time_base <= 16'h0000;
  end
  else if (tick_cnt == `SSPR_TICK_DIV - 8'h01)
  begin
    tick_cnt <= 8'h00;
    // prescaled so a full ramp fits in one counter period
    time_base <= time_base + 16'h0001;
  end
  else
    tick_cnt <= tick_cnt + 8'h01;
end

sspr_capture #(.W(`SSPR_TBW), .N(3)) u_capture (
  .clk_in(CLOCK_IN),
  .rst_n_in(RST_N_IN),
  .arm_in(arm),
  .count_in(time_base),
  .comp_in(COMP_IN),
  .cap_out(caps),
  .done_out(cap_done)
);

////////////////////////////////////////////////////////////////////////
// conversion sequence

reg [2:0] state;
reg [27:0] settle_cnt;
reg second;
reg [15:0] base;
reg [11:0] first_res;
reg [11:0] result;
reg [15:0] ref_cap;
reg div_start;
reg meas_done;
reg run;
reg zero_done;
reg span_done;
reg [11:0] zero_cal;
reg [11:0] span_cal;
reg [11:0] speed_min;
wire [27:0] quot;
wire div_done;

// channel 0 reference, channel 1 upper amp, channel 2 lower amp
wire [15:0] r_ref = caps[15:0] - base;
wire [15:0] r_up = caps[31:16] - base;
wire [15:0] r_lo = caps[47:32] - base;
wire [16:0] diff = POLARITY_SEL_OUT ? ({1'b0, r_lo} - {1'b0, r_up}) :
                   ({1'b0, r_up} - {1'b0, r_lo});
wire [15:0] diff_pos = diff[16] ? 16'h0000 : diff[15:0];
wire [11:0] q_sat = (quot[27:12] != 16'h0000) ? 12'hFFF : quot[11:0];
wire [12:0] sum = {1'b0, first_res} + {1'b0, q_sat};
wire [11:0] avg = sum[12:1];
wire [11:0] corr = (result > zero_cal) ? result - zero_cal : 12'h000;
wire [11:0] span_new = (avg > zero_cal) ? avg - zero_cal : 12'h000;

sspr_divider #(.W(28), .DW(16)) u_divider (
  .clk_in(CLOCK_IN),
  .rst_n_in(RST_N_IN),
  .start_in(div_start),
  .dividend_in({diff_pos, 12'h000}),
  .divisor_in(r_ref),
  .quotient_out(quot),
  .done_out(div_done)
);

wire apb_wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;

always @(posedge CLOCK_IN)
begin
  if (!RST_N_IN)
  begin
    state <= S_IDLE;
    settle_cnt <= 28'h0000000;
    second <= 1'b0;
    base <= 16'h0000;
    first_res <= 12'h000;
    result <= 12'h000;
    ref_cap <= 16'h0000;
    arm <= 1'b0;
    div_start <= 1'b0;
    meas_done <= 1'b0;
    zero_done <= 1'b0;
    span_done <= 1'b0;
    zero_cal <= `SSPR_RST_ZERO;
    span_cal <= `SSPR_RST_SPAN;
    POLARITY_SEL_OUT <= 1'b0;
    DISCHARGE_ON_OUT <= 1'b1;
  end
  else
  begin
    arm <= 1'b0;
    div_start <= 1'b0;
    meas_done <= 1'b0;
    // software restores calibration from nonvolatile storage here
    if (apb_wr && PADDR_IN == `SSPR_OFF_ZERO)
      zero_cal <= PWDATA_IN[11:0];
    if (apb_wr && PADDR_IN == `SSPR_OFF_SPAN)
      span_cal <= PWDATA_IN[11:0];
    case (state)
      S_IDLE:
        if (strap_ok && run)
        begin
          settle_cnt <= 28'h0000000;
          state <= S_SETTLE;
        end
      S_SETTLE:
        // switch and capacitor settle with discharge held on
        if (settle_cnt >= SETTLE_W - 28'h0000001)
          state <= S_ARM;
        else
          settle_cnt <= settle_cnt + 28'h0000001;
      S_ARM:
      begin
        base <= time_base;
        arm <= 1'b1;
        DISCHARGE_ON_OUT <= 1'b0;
        state <= S_WAIT;
      end
      S_WAIT:
        // a ramp that never trips stalls here; no timeout
        if (cap_done == 3'h7 && !arm)
        begin
          DISCHARGE_ON_OUT <= 1'b1;
          ref_cap <= r_ref;
          div_start <= 1'b1;
          state <= S_DIV;
        end
      S_DIV:
        if (div_done)
        begin
          settle_cnt <= 28'h0000000;
          if (!second)
          begin
            first_res <= q_sat;
            second <= 1'b1;
            POLARITY_SEL_OUT <= 1'b1;
            state <= S_SETTLE;
          end
          else
          begin
            result <= avg;
            second <= 1'b0;
            POLARITY_SEL_OUT <= 1'b0;
            state <= S_DONE;
          end
        end
      S_DONE:
      begin
        if (mode == `SSPR_MODE_ZERO)
        begin
          zero_cal <= result;
          zero_done <= 1'b1;
        end
        if (mode == `SSPR_MODE_FULL)
        begin
          span_cal <= span_new;
          span_done <= 1'b1;
        end
        meas_done <= 1'b1;
        settle_cnt <= 28'h0000000;
        state <= run ? S_SETTLE : S_IDLE;
      end
      default:
        state <= S_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// display frame and SPI master

reg [11:0] digits;
reg dp;
reg blank;
reg spi_busy;
reg [15:0] shreg;
reg [4:0] bitn;
reg [7:0] half_cnt;

always @*
begin
  dp = 1'b0;
  blank = 1'b0;
  case (mode)
    `SSPR_MODE_ZERO: digits = `SSPR_DISP_ZERO;
    `SSPR_MODE_FULL: digits = `SSPR_DISP_FULL;
    `SSPR_MODE_PRESS:
    begin
      digits = corr;
      dp = 1'b1;
    end
    `SSPR_MODE_SPEED:
    begin
      digits = corr;
      dp = 1'b1;
      blank = (corr < speed_min);
    end
    default:
      case (strap_code)
        `SSPR_STRAP_R100: digits = `SSPR_DISP_R100;
        `SSPR_STRAP_R30: digits = `SSPR_DISP_R30;
        default: digits = `SSPR_DISP_R15;
      endcase
  endcase
end

always @(posedge CLOCK_IN)
begin
  if (!RST_N_IN)
  begin
    spi_busy <= 1'b0;
    shreg <= 16'h0000;
    bitn <= 5'h00;
    half_cnt <= 8'h00;
    SPI_SCK_OUT <= 1'b0;
    SPI_MOSI_OUT <= 1'b0;
    SPI_CS_N_OUT <= 1'b1;
  end
  else if (!spi_busy)
  begin
    // a frame finishing while busy is dropped; the next one follows
    if (meas_done && show_en)
    begin
      shreg <= {dp, blank, 2'h0, digits};
      SPI_MOSI_OUT <= dp;
      SPI_CS_N_OUT <= 1'b0;
      spi_busy <= 1'b1;
      bitn <= 5'h00;
      half_cnt <= 8'h00;
    end
  end
  else if (half_cnt == `SSPR_SPI_HALF - 8'h01)
  begin
    half_cnt <= 8'h00;
    if (!SPI_SCK_OUT)
      SPI_SCK_OUT <= 1'b1;
    else
    begin
      SPI_SCK_OUT <= 1'b0;
      if (bitn == 5'h0F)
      begin
        spi_busy <= 1'b0;
        SPI_CS_N_OUT <= 1'b1;
      end
      else
      begin
        bitn <= bitn + 5'h01;
        shreg <= {shreg[14:0], 1'b0};
        SPI_MOSI_OUT <= shreg[14];
      end
    end
  end
  else
    half_cnt <= half_cnt + 8'h01;
end

////////////////////////////////////////////////////////////////////////
// APB slave, zero wait in access phase

reg [31:0] next_prdata;
reg next_err;

always @*
begin
  next_err = 1'b0;
  case (PADDR_IN)
    `SSPR_OFF_CTRL: next_prdata = {31'h0, run};
    `SSPR_OFF_STATUS:
      next_prdata = {21'h0, state, POLARITY_SEL_OUT, span_done, zero_done,
                     show_en, strap_ok, mode};
    `SSPR_OFF_RESULT: next_prdata = {20'h0, result};
    `SSPR_OFF_ZERO: next_prdata = {20'h0, zero_cal};
    `SSPR_OFF_SPAN: next_prdata = {20'h0, span_cal};
    `SSPR_OFF_SPEEDMIN: next_prdata = {20'h0, speed_min};
    `SSPR_OFF_REFCAP: next_prdata = {16'h0, ref_cap};
    default:
    begin
      next_prdata = 32'h00000000;
      next_err = 1'b1;
    end
  endcase
end

always @(posedge CLOCK_IN)
begin
  if (!RST_N_IN)
  begin
    PRDATA_OUT <= 32'h00000000;
    PREADY_OUT <= 1'b0;
    PSLVERR_OUT <= 1'b0;
    run <= `SSPR_RST_CTRL;
    speed_min <= `SSPR_RST_SPEEDMIN;
  end
  else
  begin
    PREADY_OUT <= PSEL_IN && !PENABLE_IN;
    PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && next_err;
    if (PSEL_IN && !PENABLE_IN)
      PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : next_prdata;
    if (apb_wr && PADDR_IN == `SSPR_OFF_CTRL)
      run <= PWDATA_IN[`SSPR_CTRL_RUN];
    if (apb_wr && PADDR_IN == `SSPR_OFF_SPEEDMIN)
      speed_min <= PWDATA_IN[11:0];
  end
end

endmodule

//--- sspr_consts.vh
// constants for the single-slope pressure readout controller
// assumes a 125 MHz system clock and a 32-bit APB register bus
`ifndef SSPR_CONSTS_VH
`define SSPR_CONSTS_VH

// clock and timing figures in their own units
`define SSPR_CLK_MHZ 125
`define SSPR_SETTLE_US 15000
`define SSPR_STARTUP_MS 2000
`define SSPR_STRAP_SAMPLE 28'h0000010
`define SSPR_TICK_DIV 8'h40
`define SSPR_SPI_HALF 8'h08

// widths
`define SSPR_TBW 16
`define SSPR_RESW 12
`define SSPR_FRAC 12

// register byte offsets
`define SSPR_OFF_CTRL 8'h00
`define SSPR_OFF_STATUS 8'h04
`define SSPR_OFF_RESULT 8'h08
`define SSPR_OFF_ZERO 8'h0C
`define SSPR_OFF_SPAN 8'h10
`define SSPR_OFF_SPEEDMIN 8'h14
`define SSPR_OFF_REFCAP 8'h18

// reset values
`define SSPR_RST_CTRL 1'h1
`define SSPR_RST_ZERO 12'h000
`define SSPR_RST_SPAN 12'hFFF
`define SSPR_RST_SPEEDMIN 12'h010

// field positions
`define SSPR_CTRL_RUN 0

// strap codes, bit 2 = strap a, bit 0 = strap c, 1 = jumper in
`define SSPR_STRAP_SPEED0 3'h0
`define SSPR_STRAP_R100 3'h1
`define SSPR_STRAP_R30 3'h2
`define SSPR_STRAP_R15 3'h3
`define SSPR_STRAP_FULL 3'h4
`define SSPR_STRAP_ZERO 3'h5
`define SSPR_STRAP_PRESS 3'h6
`define SSPR_STRAP_SPEED1 3'h7

// operating modes after decode
`define SSPR_MODE_SPEED 3'h0
`define SSPR_MODE_PRESS 3'h1
`define SSPR_MODE_ZERO 3'h2
`define SSPR_MODE_FULL 3'h3
`define SSPR_MODE_RANGE 3'h4

// display digit patterns
`define SSPR_DISP_ZERO 12'h000
`define SSPR_DISP_FULL 12'hFFF
`define SSPR_DISP_R100 12'h100
`define SSPR_DISP_R30 12'h030
`define SSPR_DISP_R15 12'h015

`endif

//--- sspr_capture.v
// three-channel input capture of the free-running time base
// assumes comparator levels arrive asynchronously from the analog side
`timescale 1ns/10ps
module sspr_capture #(
  parameter W = 16,
  parameter N = 3
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire arm_in,
  input wire [W-1:0] count_in,
  input wire [N-1:0] comp_in,
  output wire [N*W-1:0] cap_out,
  output wire [N-1:0] done_out
);

genvar i;
generate
  for (i = 0; i < N; i = i + 1)
  begin : chan
    reg sync1;
    reg sync2;
    reg sync3;
    reg done;
    reg [W-1:0] cap;
    always @(posedge clk_in)
    begin
      if (!rst_n_in)
      begin
        sync1 <= 1'b0;
        sync2 <= 1'b0;
        sync3 <= 1'b0;
        done <= 1'b0;
        cap <= {W{1'b0}};
      end
      else
      begin
        sync1 <= comp_in[i];
        sync2 <= sync1;
        sync3 <= sync2;
        if (arm_in)
          done <= 1'b0;
        else if (sync3 && !sync2 && !done)
        begin
          // latch the time base at the falling edge
          cap <= count_in;
          done <= 1'b1;
        end
      end
    end
    assign cap_out[i*W +: W] = cap;
    assign done_out[i] = done;
  end
endgenerate

endmodule

//--- sspr_divider.v
// restoring divider, one quotient bit per clock
// assumes start is a one-cycle pulse issued while not busy
`timescale 1ns/10ps
module sspr_divider #(
  parameter W = 28,
  parameter DW = 16
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire start_in,
  input wire [W-1:0] dividend_in,
  input wire [DW-1:0] divisor_in,
  output reg [W-1:0] quotient_out,
  output reg done_out
);

reg [W-1:0] num;
reg [DW:0] rem;
reg [DW-1:0] den;
reg [5:0] left;
reg busy;
wire [DW:0] trial = {rem[DW-1:0], num[W-1]};
wire [DW:0] diff = trial - {1'b0, den};

always @(posedge clk_in)
begin
  if (!rst_n_in)
  begin
    num <= {W{1'b0}};
    rem <= {(DW+1){1'b0}};
    den <= {DW{1'b0}};
    left <= 6'h00;
    busy <= 1'b0;
    quotient_out <= {W{1'b0}};
    done_out <= 1'b0;
  end
  else
  begin
    done_out <= 1'b0;
    if (start_in && !busy)
    begin
      num <= dividend_in;
      den <= divisor_in;
      rem <= {(DW+1){1'b0}};
      left <= W[5:0];
      busy <= 1'b1;
    end
    else if (busy)
    begin
      // zero divisor yields ones in the upper 16 quotient bits, which the caller saturates
      if (!diff[DW])
      begin
        rem <= diff;
        num <= {num[W-2:0], 1'b1};
      end
      else
      begin
        rem <= trial;
        num <= {num[W-2:0], 1'b0};
      end
      left <= left - 6'h01;
      if (left == 6'h01)
      begin
        busy <= 1'b0;
        done_out <= 1'b1;
        quotient_out <= !diff[DW] ? {num[W-2:0], 1'b1} : {num[W-2:0], 1'b0};
      end
    end
  end
end

endmodule

//--- sspr_checker_assertions.sv
// port-level checker for the readout controller
// assumes it is bound onto sspr_top and sees only its ports
`timescale 1ns/10ps
module sspr_checker (
  input wire CLOCK_IN,
  input wire RST_N_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PRDATA_OUT,
  input wire PREADY_OUT,
  input wire PSLVERR_OUT,
  input wire [2:0] COMP_IN,
  input wire POLARITY_SEL_OUT,
  input wire DISCHARGE_ON_OUT,
  input wire SPI_SCK_OUT,
  input wire SPI_CS_N_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  ////////////////////////////////////////////////////////////////////////
  a_ready_single: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held longer than one cycle");
  a_ready_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("no ready in the access cycle");
  a_err_decode: assert property (PREADY_OUT && PADDR_IN[1:0] == 2'b00
    |-> PSLVERR_OUT == (PADDR_IN > 8'h18))
    else $error("error response does not match address map");
  a_err_zero: assert property (PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
    else $error("error read returned data");
  // the switch may only move while the ramp is held discharged
  a_pol_at_rest: assert property ($changed(POLARITY_SEL_OUT)
    |-> DISCHARGE_ON_OUT && $past(DISCHARGE_ON_OUT))
    else $error("polarity moved during a ramp");
  a_ramp_done: assert property ($rose(DISCHARGE_ON_OUT)
    |-> COMP_IN == 3'h0)
    else $error("ramp ended before all comparators tripped");
  a_settle_hold: assert property ($rose(DISCHARGE_ON_OUT)
    |-> DISCHARGE_ON_OUT [*8])
    else $error("discharge not held for settling");
  a_sck_idle: assert property (SPI_CS_N_OUT |-> !SPI_SCK_OUT)
    else $error("serial clock moves outside a frame");
  a_frame_start: assert property ($fell(SPI_CS_N_OUT)
    |-> !SPI_SCK_OUT [*8] ##1 SPI_SCK_OUT)
    else $error("first serial clock edge misplaced");
  a_frame_length: assert property ($fell(SPI_CS_N_OUT)
    |-> ##255 !SPI_CS_N_OUT ##[1:3] SPI_CS_N_OUT)
    else $error("frame length wrong");
  c_ramp: cover property ($rose(DISCHARGE_ON_OUT));
  c_frame: cover property ($fell(SPI_CS_N_OUT));
  c_err: cover property (PSLVERR_OUT);
endmodule

bind sspr_top sspr_checker u_chk (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .COMP_IN(COMP_IN),
  .POLARITY_SEL_OUT(POLARITY_SEL_OUT), .DISCHARGE_ON_OUT(DISCHARGE_ON_OUT),
  .SPI_SCK_OUT(SPI_SCK_OUT), .SPI_CS_N_OUT(SPI_CS_N_OUT));

//--- sspr_frontend_model.sv
// behavioural analog front end: ramp, three comparators, sensor swap
// assumes trip points given in time-base counts of 64 clocks
`timescale 1ns/10ps
module sspr_frontend_model (
  input wire clk_in,
  input wire discharge_in,
  input wire polarity_in,
  input int sig_in,
  input int off_in,
  input int ref_in,
  output logic [2:0] comp_out
);
  localparam int BASE = 10;
  int ramp = 0;
  int hold = 0;
  int up;
  int lo;
  initial comp_out = 3'h7;
  // amplifier offset keeps its sign while the sensor signal flips
  always @(posedge clk_in)
  begin
    up = polarity_in ? BASE + off_in : BASE + sig_in + off_in;
    lo = polarity_in ? BASE + sig_in : BASE;
    if (discharge_in)
    begin
      ramp <= 0;
      hold <= hold + 1;
      // capacitor needs a few cycles to drop below the inputs
      if (hold >= 3)
        comp_out <= 3'h7;
    end
    else
    begin
      hold <= 0;
      ramp <= ramp + 1;
      comp_out <= {ramp < lo * 64, ramp < up * 64, ramp < ref_in * 64};
    end
  end
endmodule

//--- testbench.sv
// self-checking bench for the readout controller
// assumes the front-end model drives the comparators
`timescale 1ns/10ps
module testbench;
  logic CLOCK_IN = 1'b0;
  logic RST_N_IN = 1'b0;
  logic PSEL_IN = 1'b0;
  logic PENABLE_IN = 1'b0;
  logic PWRITE_IN = 1'b0;
  logic [7:0] PADDR_IN = 8'h00;
  logic [31:0] PWDATA_IN = 32'h0;
  logic [2:0] STRAP_N_IN = 3'h7;
  wire [31:0] PRDATA_OUT;
  wire PREADY_OUT;
  wire PSLVERR_OUT;
  wire [2:0] COMP_IN;
  wire POLARITY_SEL_OUT;
  wire DISCHARGE_ON_OUT;
  wire SPI_SCK_OUT;
  wire SPI_MOSI_OUT;
  wire SPI_CS_N_OUT;
  int sig = 0;
  int off = 0;
  int bad_count = 0;
  int total_checks = 0;
  // boot order: range codes, then zero, full, pressure, speed
  int codes [8] = '{1, 2, 3, 5, 4, 6, 7, 0};
  // 0 clamps to zero, 1 saturates, 2 mid-scale with amplifier offset
  int kinds [8] = '{0, 2, 1, 1, 0, 1, 2, 0};
  int sigs [3] = '{-6, 45, 10};
  int offs [3] = '{2, 0, 3};
  logic [15:0] frames [8] = '{16'h0100, 16'h0030, 16'h0015, 16'h0000,
    16'h0FFF, 16'h8FFF, 16'h8000, 16'hC000};
  logic [2:0] modes [8] = '{3'h4, 3'h4, 3'h4, 3'h2, 3'h3, 3'h1, 3'h0, 3'h0};

  sspr_top #(.SETTLE_CYCLES(20), .STARTUP_CYCLES(200)) dut (
    .CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .COMP_IN(COMP_IN), .STRAP_N_IN(STRAP_N_IN),
    .POLARITY_SEL_OUT(POLARITY_SEL_OUT), .DISCHARGE_ON_OUT(DISCHARGE_ON_OUT),
    .SPI_SCK_OUT(SPI_SCK_OUT), .SPI_MOSI_OUT(SPI_MOSI_OUT),
    .SPI_CS_N_OUT(SPI_CS_N_OUT));
  sspr_frontend_model fe (.clk_in(CLOCK_IN), .discharge_in(DISCHARGE_ON_OUT),
    .polarity_in(POLARITY_SEL_OUT), .sig_in(sig), .off_in(off),
    .ref_in(40), .comp_out(COMP_IN));

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #4 CLOCK_IN = ~CLOCK_IN;
  end

  initial
  begin
    repeat (100000) @(posedge CLOCK_IN);
    bad_count++;
    finish_test;
  end

  task finish_test;
    begin
      if (bad_count == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task chk(input string n, input logic [31:0] v, input logic [31:0] x);
    begin
      total_checks++;
      if (v !== x)
      begin
        bad_count++;
        $display("BAD %s expected %h seen %h", n, x, v);
      end
    end
  endtask

  // one transfer; an extra edge at the end keeps strobes from re-rising
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    begin
      PSEL_IN <= 1'b1;
      PWRITE_IN <= w;
      PADDR_IN <= a;
      PWDATA_IN <= d;
      @(posedge CLOCK_IN);
      PENABLE_IN <= 1'b1;
      @(posedge CLOCK_IN);
      // only the watchdog ends a wait for the answer
      while (PREADY_OUT !== 1'b1)
        @(posedge CLOCK_IN);
      q = PRDATA_OUT;
      e = PSLVERR_OUT;
      PSEL_IN <= 1'b0;
      PENABLE_IN <= 1'b0;
      @(posedge CLOCK_IN);
    end
  endtask

  task boot(input int code);
    begin
      STRAP_N_IN <= ~code[2:0];
      RST_N_IN <= 1'b0;
      repeat (5) @(posedge CLOCK_IN);
      RST_N_IN <= 1'b1;
      @(posedge CLOCK_IN);
    end
  endtask

  // shift register of the display link, sampled on the rising clock
  task get_frame(output logic [15:0] f);
    begin
      while (SPI_CS_N_OUT !== 1'b0)
        @(posedge CLOCK_IN);
      for (int i = 15; i >= 0; i--)
      begin
        @(posedge SPI_SCK_OUT);
        f[i] = SPI_MOSI_OUT;
      end
    end
  endtask

  // one conversion result: scaled, clamped below and saturated above
  function int qv(input int d, input int r);
    qv = d <= 0 ? 0 : (d * 4096 / r > 4095 ? 4095 : d * 4096 / r);
  endfunction

  function int avg(input int s, input int o, input int r);
    avg = (qv(s + o, r) + qv(s - o, r)) / 2;
  endfunction

  task reg_test;
    logic [31:0] q;
    logic [31:0] d;
    logic e;
    logic [7:0] ad [4];
    logic [31:0] rv [4];
    begin
      ad = '{8'h00, 8'h0C, 8'h10, 8'h14};
      rv = '{32'h1, 32'h0, 32'hFFF, 32'h10};
      for (int k = 0; k < 4; k++)
      begin
        apb(1'b0, ad[k], 32'h0, q, e);
        chk("reset_value", q, rv[k]);
      end
      for (int k = 1; k < 4; k++)
      begin
        d = $urandom;
        apb(1'b1, ad[k], d, q, e);
        apb(1'b0, ad[k], 32'h0, q, e);
        chk("readback", q, {20'h0, d[11:0]});
      end
      apb(1'b1, 8'h20, d, q, e);
      chk("write_err", e, 1'b1);
      apb(1'b0, 8'h20, 32'h0, q, e);
      chk("read_err", e, 1'b1);
      chk("read_zero", q, 32'h0);
    end
  endtask

  initial
  begin
    logic [31:0] q;
    logic e;
    logic [15:0] f;
    int k;
    void'($urandom(32'h595e));
    for (int i = 0; i < 8; i++)
    begin
      k = kinds[i];
      sig = sigs[k];
      off = offs[k];
      boot(codes[i]);
      if (i == 0)
        reg_test;
      get_frame(f);
      if (k == 2)
        chk("frame_flags", f[15:12], frames[i][15:12]);
      else
        chk("frame", f, frames[i]);
      apb(1'b0, 8'h04, 32'h0, q, e);
      chk("status", q[4:0], {2'b11, modes[i]});
      apb(1'b0, 8'h08, 32'h0, q, e);
      // reference count may land one tick above the grid
      if (k == 2)
        chk("mid_result", q >= avg(sig, off, 41) && q <= avg(sig, off, 40),
          1'b1);
      else
        chk("result", q, avg(sig, off, 40));
      apb(1'b0, 8'h18, 32'h0, q, e);
      chk("ref_count", q == 40 || q == 41, 1'b1);
      if (codes[i] == 5)
        apb(1'b0, 8'h0C, 32'h0, q, e);
      if (codes[i] == 5)
        chk("zero_store", q, 32'hFFF);
      if (codes[i] == 4)
        apb(1'b0, 8'h10, 32'h0, q, e);
      if (codes[i] == 4)
        chk("span_store", q, 32'h0);
    end
    // stopping: the measurement in flight ends with a frame, then idle
    apb(1'b1, 8'h00, 32'h0, q, e);
    get_frame(f);
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk("stopped", q[10:7], 4'h0);
    finish_test;
  end
endmodule
